// *** rtl/wtc_core.sv ***
// Watch timer core with baud generator and classic Wishbone slave
// How it works
// - Eight-bit mode register, byte access, resets zero
// - Bit 7 picks clock; bits 6..4 interval
// - Bits 3..2 pick watch interrupt period
// - Bit 1 runs or clears 5-bit counter
// - Bit 0 clear stops, clears both dividers
// - Watch counting needs bits 1 and 0
// - Bit 1 clear leaves interval timing alone
// - Generator clock gated by main clock enable
// - Generator rate is clock over 2^(m+1)*N
// - Prescaler taps watch clock /16 to /2048
// - Interval interrupt repeats beside watch interrupt
`timescale 1ns/10ps
module wtc_core (
    input wire logic clk,
    input wire logic srst,
    input wire wtc_pkg::wtc_wb_req_s wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sub_clock,
    output logic watch_irq,
    output logic interval_irq,
    output logic irq
);
    import wtc_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True when the lowest n bits of v are all ones
    function automatic logic low_ones(input logic [10:0] v,
                                      input logic [3:0] n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 11; i++) begin
            if ((i < int'(n)) && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    // Prescaler hit for the generator's 3-bit stage
    function automatic logic bg_stage_hit(input logic [2:0] p,
                                          input logic [1:0] m);
        logic [10:0] wide;
        logic [3:0] len;
        wide = {8'h00, p};
        len = {2'b00, m};
        return low_ones(wide, len);
    endfunction

    // Last count of the generator's 8-bit stage; 00 counts 256
    function automatic logic bg_last(input logic [7:0] cnt,
                                     input logic [7:0] cmp);
        logic [7:0] top;
        top = cmp - WTC_CMP_ONE;
        return cnt == top;
    endfunction

    // Low byte lane of a bus write
    function automatic logic [7:0] lane_byte(input wtc_wb_req_s r);
        return r.dat[7:0];
    endfunction

    // Low two bits of a bus write, for interrupt registers
    function automatic logic [1:0] lane_bits(input wtc_wb_req_s r);
        return r.dat[1:0];
    endfunction

    // Low byte register as a bus word, upper lanes zero
    function automatic logic [31:0] byte_word(input logic [7:0] v);
        logic [31:0] w;
        w = WTC_RD_ZERO;
        w[7:0] = v;
        return w;
    endfunction

    // Two interrupt bits as a bus word, upper lanes zero
    function automatic logic [31:0] irq_word(input logic [1:0] v);
        logic [31:0] w;
        w = WTC_RD_ZERO;
        w[1:0] = v;
        return w;
    endfunction

    // Interval tap width: base plus the three select bits
    function automatic logic [3:0] intv_width(input logic [7:0] m);
        logic [3:0] w;
        w = {1'b0, m[WTC_MODE_ISEL_MSB:WTC_MODE_ISEL_LSB]} +
            WTC_INTV_BASE;
        return w;
    endfunction

    // Last count of the 5-bit counter for the chosen length
    function automatic logic wrap_hit(input logic [4:0] c,
                                      input logic short_len);
        logic r;
        if (short_len) begin
            r = &c[3:0];
        end else begin
            r = &c;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Registered state and strobes
    // ------------------------------------------------------------------
    wtc_state_s q;
    wtc_state_s s;

    logic req_now;
    logic wr;
    logic run;
    logic cnt_en;
    logic bg_tick;
    logic brg_tick;
    logic sub_tick;
    logic fw_tick;
    logic cnt_tick;
    logic watch_fire;
    logic intv_fire;
    logic [1:0] clr_bits;
    logic [3:0] intv_bits;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        // --------------------------------------------------------------
        // Defaults
        // --------------------------------------------------------------
        s = q;
        clr_bits = 2'b00;

        // --------------------------------------------------------------
        // Bus slave: one ack cycle, then ack drops
        // --------------------------------------------------------------
        req_now = wb_req.cyc & wb_req.stb & ~q.ack;
        wr = req_now & wb_req.we & wb_req.sel[0];
        s.ack = req_now;
        s.rdata = WTC_RD_ZERO;
        if (req_now) begin
            case (wb_req.adr)
                WTC_ADR_MODE: begin
                    s.rdata = byte_word(q.mode);
                end
                WTC_ADR_BG_MODE: begin
                    s.rdata = byte_word(q.bg_mode);
                end
                WTC_ADR_BG_CMP: begin
                    s.rdata = byte_word(q.bg_cmp);
                end
                WTC_ADR_IRQ_STAT: begin
                    s.rdata = irq_word(q.irq_stat);
                end
                WTC_ADR_IRQ_EN: begin
                    s.rdata = irq_word(q.irq_en);
                end
                WTC_ADR_IRQ_CLR: begin
                    s.rdata = WTC_RD_ZERO;
                end
                default: s.rdata = WTC_RD_ZERO;
            endcase
        end

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (wr) begin
            case (wb_req.adr)
                WTC_ADR_MODE: begin
                    s.mode = lane_byte(wb_req);
                end
                WTC_ADR_BG_MODE: begin
                    s.bg_mode = lane_byte(wb_req) & WTC_BG_MODE_MASK;
                end
                WTC_ADR_BG_CMP: begin
                    s.bg_cmp = lane_byte(wb_req);
                end
                WTC_ADR_IRQ_EN: begin
                    s.irq_en = lane_bits(wb_req);
                end
                WTC_ADR_IRQ_CLR: begin
                    clr_bits = lane_bits(wb_req);
                end
                default: clr_bits = 2'b00;
            endcase
        end

        // --------------------------------------------------------------
        // Baud generator
        // --------------------------------------------------------------
        bg_tick = bg_stage_hit(q.pre3,
                               q.bg_mode[WTC_BG_DIV_MSB:WTC_BG_DIV_LSB]);
        brg_tick = 1'b0;
        // generator runs only while gated on
        if (!q.bg_mode[WTC_BG_GATE]) begin
            s.pre3 = '0;
            s.cnt8 = '0;
            s.half = 1'b0;
        end else begin
            s.pre3 = q.pre3 + 3'h1;
            if (bg_tick) begin
                // compare 00 wraps to a count of 256
                if (bg_last(q.cnt8, q.bg_cmp)) begin
                    s.cnt8 = '0;
                    s.half = ~q.half;
                    brg_tick = q.half;
                end else begin
                    s.cnt8 = q.cnt8 + 8'h01;
                end
            end
        end

        // --------------------------------------------------------------
        // Watch clock
        // --------------------------------------------------------------
        // watch clock source select
        s.sub_q = sub_clock;
        sub_tick = sub_clock & ~q.sub_q;
        if (q.mode[WTC_MODE_SRC]) begin
            fw_tick = brg_tick;
        end else begin
            fw_tick = sub_tick;
        end

        // --------------------------------------------------------------
        // Prescaler and interval taps
        // --------------------------------------------------------------
        // prescaler cleared while stopped
        run = q.mode[WTC_MODE_RUN];
        if (!run) begin
            s.pre11 = '0;
        end else if (fw_tick) begin
            s.pre11 = q.pre11 + 11'h001;
        end

        intv_bits = intv_width(q.mode);
        intv_fire = run & fw_tick & low_ones(q.pre11, intv_bits);

        // --------------------------------------------------------------
        // Watch counter
        // --------------------------------------------------------------
        // counter clock and wrap length
        if (q.mode[WTC_MODE_WSEL_HI]) begin
            cnt_tick = fw_tick;
        end else begin
            cnt_tick = fw_tick & low_ones(q.pre11, WTC_CNT_TAP);
        end
        cnt_en = run & q.mode[WTC_MODE_CNT_RUN];
        // counter cleared while bit 1 low
        if (!cnt_en) begin
            s.cnt5 = '0;
        end else if (cnt_tick) begin
            s.cnt5 = q.cnt5 + 5'h01;
        end
        watch_fire = cnt_en & cnt_tick &
                     wrap_hit(q.cnt5, q.mode[WTC_MODE_WSEL_LO]);

        // --------------------------------------------------------------
        // Interrupt requests and status
        // --------------------------------------------------------------
        // one-cycle request pulses
        s.watch_irq = watch_fire;
        s.interval_irq = intv_fire;

        // Sticky status, set beats clear
        s.irq_stat = q.irq_stat & ~clr_bits;
        if (watch_fire) begin
            s.irq_stat[WTC_IRQ_WATCH] = 1'b1;
        end
        if (intv_fire) begin
            s.irq_stat[WTC_IRQ_INTV] = 1'b1;
        end
        s.irq = |(s.irq_stat & s.irq_en);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= WTC_STATE_RST;
        end else begin
            q <= s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, straight from the state register
    // ------------------------------------------------------------------
    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;
    assign watch_irq = q.watch_irq;
    assign interval_irq = q.interval_irq;
    assign irq = q.irq;

endmodule

// *** rtl/wtc_pkg.sv ***
// Constants, field layouts and carrier types for the watch timer core
package wtc_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] WTC_ADR_MODE = 32'hfffff680;
    localparam logic [31:0] WTC_ADR_BG_MODE = 32'hfffff684;
    localparam logic [31:0] WTC_ADR_BG_CMP = 32'hfffff688;
    localparam logic [31:0] WTC_ADR_IRQ_STAT = 32'hfffff68c;
    localparam logic [31:0] WTC_ADR_IRQ_EN = 32'hfffff690;
    localparam logic [31:0] WTC_ADR_IRQ_CLR = 32'hfffff694;

    // ------------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------------
    localparam int WTC_MODE_RUN = 0;
    localparam int WTC_MODE_CNT_RUN = 1;
    localparam int WTC_MODE_WSEL_LO = 2;
    localparam int WTC_MODE_WSEL_HI = 3;
    localparam int WTC_MODE_ISEL_LSB = 4;
    localparam int WTC_MODE_ISEL_MSB = 6;
    localparam int WTC_MODE_SRC = 7;

    // ------------------------------------------------------------------
    // Baud generator mode fields
    // ------------------------------------------------------------------
    localparam int WTC_BG_DIV_LSB = 0;
    localparam int WTC_BG_DIV_MSB = 1;
    localparam int WTC_BG_GATE = 4;
    localparam logic [7:0] WTC_BG_MODE_MASK = 8'h13;

    // ------------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------------
    localparam int WTC_IRQ_WATCH = 0;
    localparam int WTC_IRQ_INTV = 1;

    // ------------------------------------------------------------------
    // Divider figures
    // ------------------------------------------------------------------
    localparam logic [3:0] WTC_INTV_BASE = 4'h4;
    localparam logic [3:0] WTC_CNT_TAP = 4'h9;
    localparam logic [7:0] WTC_CMP_ONE = 8'h01;
    localparam logic [31:0] WTC_RD_ZERO = 32'h00000000;

    // ------------------------------------------------------------------
    // Carrier and state types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wtc_wb_req_s;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] bg_mode;
        logic [7:0] bg_cmp;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic [2:0] pre3;
        logic [7:0] cnt8;
        logic half;
        logic sub_q;
        logic [10:0] pre11;
        logic [4:0] cnt5;
        logic watch_irq;
        logic interval_irq;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } wtc_state_s;

    localparam wtc_state_s WTC_STATE_RST = '0;

endpackage

// *** tb/tb.sv ***
// Self-checking bench for the watch timer core
`timescale 1ns/10ps
module tb;
    import wtc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sub_clock = 1'b0;
    logic sub_run = 1'b0;
    wtc_wb_req_s wb_req = '0;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic wb_ack_o, watch_irq, interval_irq, irq;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_cyc = 0;
    always #50 clk = ~clk;
    always @(posedge clk) n_cyc <= n_cyc + 1;
    // Subclock tick every two cycles, idle low
    always @(posedge clk) sub_clock <= sub_run & ~sub_clock;
    wtc_core dut (.clk(clk), .srst(srst), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sub_clock(sub_clock),
        .watch_irq(watch_irq), .interval_irq(interval_irq), .irq(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wb(input int we, input logic [31:0] a, input logic [7:0] d);
        int i;
        i = 0;
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we != 0, a, 4'h1, {24'h0, d}};
        do begin
            @(posedge clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        rd = wb_dat_o;
        wb_req <= '0;
    endtask
    task automatic wait_irq(input int s, input int lim, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((s != 0 ? interval_irq : watch_irq) !== 1'b1 && n < lim);
        if ((s != 0 ? interval_irq : watch_irq) !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic chk_irq(input int e);
        repeat (2) @(negedge clk);
        check({31'h0, irq}, {31'h0, e[0]});
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_period(input logic [7:0] c, input int s, input int e);
        int n;
        wb(1, WTC_ADR_MODE, c & 8'hfc);
        wb(1, WTC_ADR_MODE, c);
        wait_irq(s, 20000, n);
        wait_irq(s, 20000, n);
        check(n, e);
        wb(1, WTC_ADR_MODE, c & 8'hfc);
        wb(1, WTC_ADR_MODE, 8'h00);
    endtask
    task automatic t_regs();
        wb(0, WTC_ADR_MODE, 8'h00);
        check(rd, 32'h0);
        wb(1, WTC_ADR_MODE, 8'hfc);
        wb(0, WTC_ADR_MODE, 8'h00);
        check(rd, 32'hfc);
        wb(1, WTC_ADR_MODE, 8'h00);
        wb(0, 32'hfffff6a0, 8'h00);
        check(rd, 32'h0);
    endtask
    task automatic t_baud();
        int n;
        sub_run <= 1'b0;
        wb(1, WTC_ADR_BG_CMP, 8'h01);
        wb(1, WTC_ADR_BG_MODE, 8'h03);
        wb(1, WTC_ADR_MODE, 8'h80);
        wb(1, WTC_ADR_MODE, 8'h81);
        n = 0;
        repeat (500) begin
            @(negedge clk);
            if (interval_irq !== 1'b0) n++;
        end
        check(n, 0);
        wb(1, WTC_ADR_MODE, 8'h80);
        wb(1, WTC_ADR_MODE, 8'h00);
        wb(1, WTC_ADR_BG_MODE, 8'h13);
        t_period(8'h81, 1, 256);
        wb(1, WTC_ADR_BG_CMP, 8'h00);
        wb(1, WTC_ADR_BG_MODE, 8'h10);
        t_period(8'h81, 1, 8192);
        // N and m for a 32.768 kHz watch clock from the 10 MHz clock
        wb(1, WTC_ADR_BG_CMP, 8'h99);
        t_period(8'h81, 1, 4896);
    endtask
    task automatic t_irq();
        int n;
        sub_run <= 1'b1;
        wb(1, WTC_ADR_IRQ_EN, 8'h01);
        wb(1, WTC_ADR_MODE, 8'h0c);
        wb(1, WTC_ADR_MODE, 8'h0f);
        wait_irq(0, 20000, n);
        check({31'h0, irq}, 32'h1);
        wb(1, WTC_ADR_MODE, 8'h0c);
        wb(1, WTC_ADR_MODE, 8'h00);
        wb(0, WTC_ADR_IRQ_STAT, 8'h00);
        check(rd & 32'h1, 32'h1);
        wb(1, WTC_ADR_IRQ_EN, 8'h00);
        chk_irq(0);
        wb(1, WTC_ADR_IRQ_EN, 8'h01);
        chk_irq(1);
        wb(1, WTC_ADR_IRQ_CLR, 8'h03);
        chk_irq(0);
    endtask
    task automatic t_adjust();
        int n;
        int t0;
        int w;
        sub_run <= 1'b1;
        wb(1, WTC_ADR_MODE, 8'h0c);
        wb(1, WTC_ADR_MODE, 8'h0f);
        wait_irq(1, 20000, n);
        t0 = n_cyc;
        wb(1, WTC_ADR_MODE, 8'h0d);
        wait_irq(1, 20000, n);
        check(n_cyc - t0, 32);
        w = 0;
        repeat (64) begin
            @(negedge clk);
            if (watch_irq !== 1'b0) w++;
        end
        check(w, 0);
        wb(1, WTC_ADR_MODE, 8'h0c);
        wb(1, WTC_ADR_MODE, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        sub_run <= 1'b1;
        // Interval alone, watch counter held clear
        for (int k = 0; k < 8; k++) t_period({1'b0, k[2:0], 4'h1}, 1, 32 << k);
        t_period(8'h0f, 0, 32);
        t_period(8'h0b, 0, 64);
        t_period(8'h07, 0, 16384);
        t_baud();
        t_irq();
        t_adjust();
        end_sim();
    end
endmodule

// *** tb/wtc_monitor.sv ***
// Port checker for the watch timer core
`timescale 1ns/10ps
module wtc_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire wtc_pkg::wtc_wb_req_s wb_req,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sub_clock,
    input wire logic watch_irq,
    input wire logic interval_irq,
    input wire logic irq
);
    import wtc_pkg::*;
    logic [7:0] mode_ff;
    logic [1:0] en_ff;
    logic wr;
    // Shadow follows the edge at which the core takes the write
    assign wr = wb_req.cyc && wb_req.stb && !wb_ack_o &&
        wb_req.we && wb_req.sel[0];
    // Shadow of what software wrote
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_ff <= 8'h00;
            en_ff <= 2'h0;
        end else begin
            if (wr && wb_req.adr == WTC_ADR_MODE) mode_ff <= wb_req.dat[7:0];
            if (wr && wb_req.adr == WTC_ADR_IRQ_EN) en_ff <= wb_req.dat[1:0];
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_taken;
        wb_req.cyc && wb_req.stb && !wb_ack_o;
    endsequence
    sequence s_rd_mode;
        wb_ack_o && !wb_req.we && wb_req.adr == WTC_ADR_MODE;
    endsequence
    a_ack_after_req: assert property (s_taken |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_mode_read_back: assert property (s_rd_mode |-> wb_dat_o[7:0] == mode_ff)
        else $error("mode read back wrong");
    a_watch_pulse: assert property (watch_irq |=> !watch_irq)
        else $error("watch pulse too long");
    a_intv_pulse: assert property (interval_irq |=> !interval_irq)
        else $error("interval pulse too long");
    a_stop_quiet: assert property (!mode_ff[0] && !$past(mode_ff[0])
        |-> !watch_irq && !interval_irq)
        else $error("event while stopped");
    a_watch_needs_both: assert property (!(&mode_ff[1:0])
        && !$past(&mode_ff[1:0]) |-> !watch_irq)
        else $error("watch event without both run bits");
    a_irq_masked: assert property (en_ff == 2'h0 && $past(en_ff) == 2'h0
        |-> !irq)
        else $error("irq while masked");
endmodule
bind wtc_core wtc_monitor u_mon (.clk(clk), .srst(srst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sub_clock(sub_clock),
    .watch_irq(watch_irq), .interval_irq(interval_irq), .irq(irq));
